// ==== rtl/vtor_top.sv ====
// Vertical timing assembly, line-compare split, panning and row preset logic
//
// Summary of operation
// [R1] Line compare is ten bits: low byte, overflow bit 4, max-scan bit 6.
// [R2] Matching line compare in active area restarts memory address at zero.
// [R3] Upper part starts at programmed start address, lower part at byte zero.
// [R4] Software normally sets line compare beyond the active area.
// [R5] Mode bit selects ten-bit standard or twelve-bit extended vertical values.
// [R6] Standard blank start: low byte, overflow bit 3, max-scan bit 5.
// [R7] Extended blank start upper nibble from extension register, overflow bits ignored.
// [R8] Standard sync start: low byte, overflow bit 2, overflow bit 7.
// [R9] Extended sync start upper nibble from extension register, overflow bits ignored.
// [R10] Standard display end: low byte, overflow bit 1, overflow bit 6.
// [R11] Extended display end upper nibble from extension register, overflow bits ignored.
// [R12] Software sets display end to active lines minus one.
// [R13] Standard total: low byte, overflow bit 0, overflow bit 5.
// [R14] Extended total upper nibble from extension register, overflow bits ignored.
// [R15] Software sets vertical total to total lines minus two.
// [R16] Software sets blank and sync start to their starting line index.
// [R17] Byte pan field shifts image left zero to three characters.
// [R18] Byte pan gives steps of nine pixels in 9-dot text, else eight.
// [R19] Pixel pan value adds single-pixel shifts on top of byte pan.
// [R20] Starting row scan selects first box line shown in top text row.
// [R21] Software normally leaves starting row scan at zero.
// [R22] Reserved preset bit 7 reads zero and ignores writes.
`timescale 1ns/10ps

module vtor_top
    import vtor_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [15:0]  io_addr,
    input  wire logic         io_wr,
    input  wire logic         io_rd,
    input  wire logic [7:0]   io_wdata,
    output logic      [7:0]   io_rdata,
    output logic              io_rvalid,
    input  wire logic         ext_mode,
    input  wire logic [3:0]   pixel_pan,
    input  wire logic         char_9dot,
    input  wire logic         line_start,
    input  wire logic [15:0]  row_pitch,
    output vtor_timing_t      timing,
    output logic      [11:0]  line_count,
    output logic              vactive,
    output logic              vblank,
    output logic              vsync,
    output logic              split_active,
    output logic      [15:0]  mem_addr,
    output logic      [4:0]   row_scan,
    output logic      [5:0]   pan_shift
);

    logic [7:0]   index_reg;
    logic [7:0]   vtotal_reg;
    logic [7:0]   overflow_reg;
    logic [6:0]   preset_row_reg;
    logic [7:0]   max_scanline_reg;
    logic [7:0]   start_addr_high_reg;
    logic [7:0]   start_addr_low_reg;
    logic [7:0]   vsync_start_reg;
    logic [7:0]   vdisp_end_reg;
    logic [7:0]   vblank_start_reg;
    logic [7:0]   line_compare_low_reg;
    logic [7:0]   ext_vtotal_reg;
    logic [7:0]   ext_vdisp_end_reg;
    logic [7:0]   ext_vsync_start_reg;
    logic [7:0]   ext_vblank_start_reg;
    logic         index_hit;
    logic         data_hit;
    logic [7:0]   next_rdata;
    vtor_timing_t next_timing;
    logic [11:0]  next_count;
    logic [11:0]  vsync_end;
    logic         next_in_active;
    logic [5:0]   pan_base;

    // Port decode accepts both the mono and colour address pairs
    assign index_hit = (io_addr == IO_INDEX_MONO) || (io_addr == IO_INDEX_COLOR);
    assign data_hit  = (io_addr == IO_DATA_MONO) || (io_addr == IO_DATA_COLOR);

    // Index register selects which timing register the data port reaches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_reg <= RST_REG;
        end else if (io_wr && index_hit) begin
            index_reg <= io_wdata;
        end
    end

    // Data port writes; unmapped indices are dropped silently
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vtotal_reg           <= RST_REG;
            overflow_reg         <= RST_REG;
            preset_row_reg       <= RST_PRESET;
            max_scanline_reg     <= RST_REG;
            start_addr_high_reg  <= RST_REG;
            start_addr_low_reg   <= RST_REG;
            vsync_start_reg      <= RST_REG;
            vdisp_end_reg        <= RST_REG;
            vblank_start_reg     <= RST_REG;
            line_compare_low_reg <= RST_REG;
            ext_vtotal_reg       <= RST_REG;
            ext_vdisp_end_reg    <= RST_REG;
            ext_vsync_start_reg  <= RST_REG;
            ext_vblank_start_reg <= RST_REG;
        end else if (io_wr && data_hit) begin
            unique case (index_reg)
                IDX_VTOTAL:       vtotal_reg           <= io_wdata;
                IDX_OVERFLOW:     overflow_reg         <= io_wdata;
                IDX_PRESET_ROW:   preset_row_reg       <= io_wdata[6:0]; // [R22]
                IDX_MAX_SCAN:     max_scanline_reg     <= io_wdata;
                IDX_START_HIGH:   start_addr_high_reg  <= io_wdata;
                IDX_START_LOW:    start_addr_low_reg   <= io_wdata;
                IDX_VSYNC_START:  vsync_start_reg      <= io_wdata;
                IDX_VDISP_END:    vdisp_end_reg        <= io_wdata;
                IDX_VBLANK_START: vblank_start_reg     <= io_wdata;
                IDX_LINE_CMP:     line_compare_low_reg <= io_wdata;
                IDX_EXT_VTOTAL:   ext_vtotal_reg       <= io_wdata;
                IDX_EXT_VDISP:    ext_vdisp_end_reg    <= io_wdata;
                IDX_EXT_VSYNC:    ext_vsync_start_reg  <= io_wdata;
                IDX_EXT_VBLANK:   ext_vblank_start_reg <= io_wdata;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped indices read as zero
    always_comb begin
        next_rdata = RST_REG;
        if (index_hit) begin
            next_rdata = index_reg;
        end else if (data_hit) begin
            unique case (index_reg)
                IDX_VTOTAL:       next_rdata = vtotal_reg;
                IDX_OVERFLOW:     next_rdata = overflow_reg;
                IDX_PRESET_ROW:   next_rdata = {1'b0, preset_row_reg}; // [R22]
                IDX_MAX_SCAN:     next_rdata = max_scanline_reg;
                IDX_START_HIGH:   next_rdata = start_addr_high_reg;
                IDX_START_LOW:    next_rdata = start_addr_low_reg;
                IDX_VSYNC_START:  next_rdata = vsync_start_reg;
                IDX_VDISP_END:    next_rdata = vdisp_end_reg;
                IDX_VBLANK_START: next_rdata = vblank_start_reg;
                IDX_LINE_CMP:     next_rdata = line_compare_low_reg;
                IDX_EXT_VTOTAL:   next_rdata = ext_vtotal_reg;
                IDX_EXT_VDISP:    next_rdata = ext_vdisp_end_reg;
                IDX_EXT_VSYNC:    next_rdata = ext_vsync_start_reg;
                IDX_EXT_VBLANK:   next_rdata = ext_vblank_start_reg;
                default:          next_rdata = RST_REG;
            endcase
        end
    end

    // Read data is registered and flagged for one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata  <= RST_REG;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd && (index_hit || data_hit);
            if (io_rd) begin
                io_rdata <= next_rdata;
            end
        end
    end

    // Assemble vertical values; extended mode ignores the overflow bits except in line compare
    always_comb begin
        next_timing.line_cmp = {2'b00, max_scanline_reg[MS_LCMP_B9], overflow_reg[OV_LCMP_B8],
                                line_compare_low_reg}; // [R1]
        if (ext_mode) begin // [R5]
            next_timing.vtotal       = {ext_vtotal_reg[3:0], vtotal_reg}; // [R14]
            next_timing.vdisp_end    = {ext_vdisp_end_reg[3:0], vdisp_end_reg}; // [R11]
            next_timing.vblank_start = {ext_vblank_start_reg[3:0], vblank_start_reg}; // [R7]
            next_timing.vsync_start  = {ext_vsync_start_reg[3:0], vsync_start_reg}; // [R9]
        end else begin
            next_timing.vtotal       = {2'b00, overflow_reg[OV_VTOTAL_B9], overflow_reg[OV_VTOTAL_B8],
                                        vtotal_reg}; // [R13]
            next_timing.vdisp_end    = {2'b00, overflow_reg[OV_VDISP_B9], overflow_reg[OV_VDISP_B8],
                                        vdisp_end_reg}; // [R10]
            next_timing.vblank_start = {2'b00, max_scanline_reg[MS_VBLANK_B9], overflow_reg[OV_VBLANK_B8],
                                        vblank_start_reg}; // [R6]
            next_timing.vsync_start  = {2'b00, overflow_reg[OV_VSYNC_B9], overflow_reg[OV_VSYNC_B8],
                                        vsync_start_reg}; // [R8]
        end
    end

    // Registered copy keeps the counter path off the register mux
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timing <= '0;
        end else begin
            timing <= next_timing;
        end
    end

    // Frame holds total plus two lines, so the last index is total plus one
    assign next_count     = (line_count == timing.vtotal + 12'h001) ? 12'h000 : line_count + 12'h001;
    assign next_in_active = next_count <= timing.vdisp_end;
    assign vsync_end      = timing.vsync_start + VSYNC_LINES;

    // Scan line counter and vertical flags, advanced once per line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_count <= 12'h000;
            vactive    <= 1'b1;
            vblank     <= 1'b0;
            vsync      <= 1'b0;
        end else if (line_start) begin
            line_count <= next_count;
            vactive    <= next_in_active;
            if (next_count == 12'h000) begin
                vblank <= 1'b0;
            end else if (next_count == timing.vblank_start) begin
                vblank <= 1'b1;
            end
            vsync <= (next_count >= timing.vsync_start) && (next_count < vsync_end);
        end
    end

    // Address and row scan; the split restart overrides the normal row advance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_addr     <= 16'h0000;
            row_scan     <= 5'h00;
            split_active <= 1'b0;
        end else if (line_start) begin
            if (next_count == 12'h000) begin
                mem_addr     <= {start_addr_high_reg, start_addr_low_reg}; // [R3]
                row_scan     <= preset_row_reg[PR_ROW_HI:0]; // [R20]
                split_active <= 1'b0;
            end else if (next_in_active && next_count == timing.line_cmp) begin
                mem_addr     <= 16'h0000; // [R2] [R3]
                row_scan     <= 5'h00;
                split_active <= 1'b1;
            end else if (row_scan == max_scanline_reg[4:0]) begin
                mem_addr <= mem_addr + row_pitch;
                row_scan <= 5'h00;
            end else begin
                row_scan <= row_scan + 5'h01;
            end
        end
    end

    // Byte pan step depends on the character box width
    always_comb begin
        unique case (preset_row_reg[PR_PAN_HI:PR_PAN_LO]) // [R17]
            2'b00: pan_base = 6'h00;
            2'b01: pan_base = char_9dot ? PAN_STEP9 : PAN_STEP8; // [R18]
            2'b10: pan_base = char_9dot ? PAN_STEP9 + PAN_STEP9 : PAN_STEP8 + PAN_STEP8;
            2'b11: pan_base = char_9dot ? PAN_STEP9 + PAN_STEP9 + PAN_STEP9
                                        : PAN_STEP8 + PAN_STEP8 + PAN_STEP8;
        endcase
    end

    // Total left shift; 27 plus 15 still fits six bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pan_shift <= 6'h00;
        end else begin
            pan_shift <= pan_base + {2'b00, pixel_pan}; // [R19]
        end
    end

    // Checks on assembly, split, panning and register reads
    sequence s_cmp_hit;
        line_start && next_in_active && next_count != 12'h000 && next_count == timing.line_cmp;
    endsequence

    sequence s_restarted;
        mem_addr == 16'h0000 && row_scan == 5'h00 && split_active;
    endsequence

    property p_line_cmp;
        @(posedge clk) disable iff (rst)
        1'b1 |=> timing.line_cmp == {2'b00, $past(max_scanline_reg[6]), $past(overflow_reg[4]),
                                     $past(line_compare_low_reg)};
    endproperty
    a_line_cmp: assert property (p_line_cmp) else $error("line compare bits misplaced"); // [R1]

    property p_split_restart;
        @(posedge clk) disable iff (rst)
        s_cmp_hit |=> s_restarted;
    endproperty
    a_split_restart: assert property (p_split_restart) else $error("split did not restart at zero"); // [R2]

    property p_split_holds;
        @(posedge clk) disable iff (rst)
        split_active && !(line_start && next_count == 12'h000) |=> split_active;
    endproperty
    a_split_holds: assert property (p_split_holds) else $error("split dropped mid frame"); // [R2]

    property p_top_start;
        @(posedge clk) disable iff (rst)
        line_start && next_count == 12'h000 |=>
            mem_addr == $past({start_addr_high_reg, start_addr_low_reg}) && !split_active;
    endproperty
    a_top_start: assert property (p_top_start) else $error("top part not at start address"); // [R3]

    property p_std_mode;
        @(posedge clk) disable iff (rst)
        !ext_mode |=> timing.vtotal[11:10] == 2'b00 && timing.vdisp_end[9] == $past(overflow_reg[6])
                      && timing.vsync_start[9:8] == $past({overflow_reg[7], overflow_reg[2]})
                      && timing.vblank_start[9:8] == $past({max_scanline_reg[5], overflow_reg[3]});
    endproperty
    a_std_mode: assert property (p_std_mode) else $error("standard mode overflow bits wrong"); // [R5] [R6] [R8] [R10] [R13]

    property p_ext_mode;
        @(posedge clk) disable iff (rst)
        ext_mode |=> timing.vtotal[11:8] == $past(ext_vtotal_reg[3:0])
                     && timing.vdisp_end[11:8] == $past(ext_vdisp_end_reg[3:0])
                     && timing.vsync_start[11:8] == $past(ext_vsync_start_reg[3:0])
                     && timing.vblank_start[11:8] == $past(ext_vblank_start_reg[3:0]);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("extended upper nibble wrong"); // [R7] [R9] [R11] [R14]

    property p_pan_nine;
        @(posedge clk) disable iff (rst)
        char_9dot && preset_row_reg[6:5] == 2'b11 |=> pan_shift == 6'h1B + {2'b00, $past(pixel_pan)};
    endproperty
    a_pan_nine: assert property (p_pan_nine) else $error("nine dot pan not 27 plus pixel pan"); // [R17] [R18] [R19]

    property p_pan_eight;
        @(posedge clk) disable iff (rst)
        !char_9dot && preset_row_reg[6:5] == 2'b10 |=> pan_shift == 6'h10 + {2'b00, $past(pixel_pan)};
    endproperty
    a_pan_eight: assert property (p_pan_eight) else $error("eight dot pan not 16 plus pixel pan"); // [R18] [R19]

    property p_row_preset;
        @(posedge clk) disable iff (rst)
        line_start && next_count == 12'h000 |=> row_scan == $past(preset_row_reg[4:0]);
    endproperty
    a_row_preset: assert property (p_row_preset) else $error("top row did not start at preset"); // [R20]

    property p_rsvd_bit;
        @(posedge clk) disable iff (rst)
        io_rd && data_hit && index_reg == IDX_PRESET_ROW |=> io_rvalid && !io_rdata[7];
    endproperty
    a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved preset bit read as one"); // [R22]

endmodule

// ==== rtl/vtor_pkg.sv ====
// Constants and carrier types for the vertical timing and row preset block
package vtor_pkg;

    // Indexed I/O port addresses (monochrome and colour decodes)
    localparam logic [15:0] IO_INDEX_MONO  = 16'h03B4;
    localparam logic [15:0] IO_DATA_MONO   = 16'h03B5;
    localparam logic [15:0] IO_INDEX_COLOR = 16'h03D4;
    localparam logic [15:0] IO_DATA_COLOR  = 16'h03D5;

    // Register indices behind the data port
    localparam logic [7:0] IDX_VTOTAL      = 8'h06;
    localparam logic [7:0] IDX_OVERFLOW    = 8'h07;
    localparam logic [7:0] IDX_PRESET_ROW  = 8'h08;
    localparam logic [7:0] IDX_MAX_SCAN    = 8'h09;
    localparam logic [7:0] IDX_START_HIGH  = 8'h0C;
    localparam logic [7:0] IDX_START_LOW   = 8'h0D;
    localparam logic [7:0] IDX_VSYNC_START = 8'h10;
    localparam logic [7:0] IDX_VDISP_END   = 8'h12;
    localparam logic [7:0] IDX_VBLANK_START = 8'h15;
    localparam logic [7:0] IDX_LINE_CMP    = 8'h18;
    localparam logic [7:0] IDX_EXT_VTOTAL  = 8'h30;
    localparam logic [7:0] IDX_EXT_VDISP   = 8'h31;
    localparam logic [7:0] IDX_EXT_VSYNC   = 8'h32;
    localparam logic [7:0] IDX_EXT_VBLANK  = 8'h33;

    // Overflow register field positions
    localparam int OV_VTOTAL_B8  = 0;
    localparam int OV_VDISP_B8   = 1;
    localparam int OV_VSYNC_B8   = 2;
    localparam int OV_VBLANK_B8  = 3;
    localparam int OV_LCMP_B8    = 4;
    localparam int OV_VTOTAL_B9  = 5;
    localparam int OV_VDISP_B9   = 6;
    localparam int OV_VSYNC_B9   = 7;
    // Maximum scan line register field positions
    localparam int MS_VBLANK_B9  = 5;
    localparam int MS_LCMP_B9    = 6;
    // Preset row register fields
    localparam int PR_PAN_HI     = 6;
    localparam int PR_PAN_LO     = 5;
    localparam int PR_ROW_HI     = 4;

    // Reset values (none documented, all registers clear)
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [6:0] RST_PRESET  = 7'h00;

    // Pan step sizes in pixels and vertical sync length in lines
    localparam logic [5:0] PAN_STEP9   = 6'h09;
    localparam logic [5:0] PAN_STEP8   = 6'h08;
    localparam logic [11:0] VSYNC_LINES = 12'h002;

    // Assembled vertical timing values
    typedef struct packed {
        logic [11:0] vtotal;
        logic [11:0] vdisp_end;
        logic [11:0] vblank_start;
        logic [11:0] vsync_start;
        logic [11:0] line_cmp;
    } vtor_timing_t;

endpackage

// ==== verification/vtor_host_model.sv ====
// Host side model: indexed register accesses and scan line pulses
`timescale 1ns/10ps

module vtor_host_model
    import vtor_pkg::*;
(
    input  wire logic        clk,
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata,
    output logic             line_start
);
    // Idle bus at time zero
    initial begin
        io_addr    = 16'h0000;
        io_wr      = 1'b0;
        io_rd      = 1'b0;
        io_wdata   = 8'h00;
        line_start = 1'b0;
    end

    // Index then data on back-to-back edges; data lines are inverted afterwards so stale data never looks valid
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        io_addr  <= IO_INDEX_COLOR;
        io_wr    <= 1'b1;
        io_wdata <= idx;
        @(posedge clk);
        io_addr  <= IO_DATA_COLOR;
        io_wdata <= val;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_wdata <= ~val;
    endtask

    // Select index, then pulse a read on the colour or mono pair; caller samples the answer just after return
    task automatic rd(input logic [7:0] idx, input logic mono = 1'b0);
        @(posedge clk);
        io_addr  <= mono ? IO_INDEX_MONO : IO_INDEX_COLOR;
        io_wr    <= 1'b1;
        io_wdata <= idx;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_rd    <= 1'b1;
        io_addr  <= mono ? IO_DATA_MONO : IO_DATA_COLOR;
        io_wdata <= ~idx;
        @(posedge clk);
        io_rd    <= 1'b0;
    endtask

    // One scan line start; a task call always lets an edge pass, so pulses are two cycles apart
    task automatic line_pulse();
        @(posedge clk);
        line_start <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
    endtask

    // Frame set-up the way driver software does it, all values below 256 lines
    task automatic program_frame(input int total, input int active, input int blank_line, input int sync_line);
        wr(IDX_VTOTAL, 8'(total - 2));
        wr(IDX_VDISP_END, 8'(active - 1));
        wr(IDX_VBLANK_START, 8'(blank_line));
        wr(IDX_VSYNC_START, 8'(sync_line));
        wr(IDX_OVERFLOW, 8'h00);
        wr(IDX_LINE_CMP, 8'(active + 1));
        wr(IDX_PRESET_ROW, 8'h00);
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the vertical timing and row preset block
`timescale 1ns/10ps

module tb_top
    import vtor_pkg::*;
;
    logic         clk;
    logic         rst;
    logic [15:0]  io_addr;
    logic         io_wr;
    logic         io_rd;
    logic [7:0]   io_wdata;
    logic [7:0]   io_rdata;
    logic         io_rvalid;
    logic         ext_mode;
    logic [3:0]   pixel_pan;
    logic         char_9dot;
    logic         line_start;
    logic [15:0]  row_pitch;
    vtor_timing_t timing;
    logic [11:0]  line_count;
    logic         vactive;
    logic         vblank;
    logic         vsync;
    logic         split_active;
    logic [15:0]  mem_addr;
    logic [4:0]   row_scan;
    logic [5:0]   pan_shift;
    int           num_errors = 0;
    int           compares = 0;
    int           cycles = 0;
    logic [15:0]  exp_mem [1:6] = '{16'h1284, 16'h1284, 16'h12D4, 16'h0000, 16'h0000, 16'h0050};
    logic [4:0]   exp_row [1:6] = '{5'h00, 5'h01, 5'h00, 5'h00, 5'h01, 5'h00};

    vtor_top vtor_top_i (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .ext_mode(ext_mode),
        .pixel_pan(pixel_pan), .char_9dot(char_9dot), .line_start(line_start), .row_pitch(row_pitch),
        .timing(timing), .line_count(line_count), .vactive(vactive), .vblank(vblank), .vsync(vsync),
        .split_active(split_active), .mem_addr(mem_addr), .row_scan(row_scan), .pan_shift(pan_shift));

    vtor_host_model host_i (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .line_start(line_start));

    // 50 MHz clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // Hang guard: the whole sequence needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Timing outputs settle two edges after the last write
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic read_chk(input logic [7:0] idx, input logic [7:0] exp, input logic mono = 1'b0);
        host_i.rd(idx, mono);
        #1;
        check(16'(io_rvalid), 16'h0001);
        check(16'(io_rdata), 16'(exp));
    endtask

    // Standard mode assembly for one overflow and max-scan pattern
    task automatic std_chk(input logic [7:0] ov, input logic [7:0] ms);
        host_i.wr(IDX_OVERFLOW, ov);
        host_i.wr(IDX_MAX_SCAN, ms);
        settle();
        check(16'(timing.vtotal), {6'h00, ov[5], ov[0], 8'h11});
        check(16'(timing.vdisp_end), {6'h00, ov[6], ov[1], 8'h22});
        check(16'(timing.vsync_start), {6'h00, ov[7], ov[2], 8'h33});
        check(16'(timing.vblank_start), {6'h00, ms[5], ov[3], 8'h44});
        check(16'(timing.line_cmp), {6'h00, ms[6], ov[4], 8'h55});
        read_chk(IDX_OVERFLOW, ov);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rst       = 1'b1;
        ext_mode  = 1'b0;
        pixel_pan = 4'h0;
        char_9dot = 1'b0;
        row_pitch = 16'h0050;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Overflow bits land in the right place in standard mode
        host_i.wr(IDX_VTOTAL, 8'h11);
        host_i.wr(IDX_VDISP_END, 8'h22);
        host_i.wr(IDX_VSYNC_START, 8'h33);
        host_i.wr(IDX_VBLANK_START, 8'h44);
        host_i.wr(IDX_LINE_CMP, 8'h55);
        std_chk(8'hA5, 8'h60);
        std_chk(8'h5A, 8'h00);
        $display("test standard assembly done");
        // Extended mode takes nibbles from the extension registers and drops overflow bits; line compare still uses them
        for (int i = 0; i < 4; i++) host_i.wr(IDX_EXT_VTOTAL + 8'(i), 8'hF1 + 8'(i));
        ext_mode <= 1'b1;
        std_chk_ext();
        @(posedge clk);
        ext_mode <= 1'b0;
        read_chk(8'h40, 8'h00);
        $display("test extended assembly done");
        // Byte pan codes in both box widths, with pixel pan on top; bit 7 set in every write
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 2; n++) begin
                host_i.wr(IDX_PRESET_ROW, {1'b1, 2'(c), 5'h00});
                char_9dot <= n[0];
                pixel_pan <= 4'(c * 5);
                settle();
                check(16'(pan_shift), 16'(c * (n == 1 ? 9 : 8) + c * 5));
            end
        end
        host_i.wr(IDX_PRESET_ROW, 8'hFF);
        read_chk(IDX_PRESET_ROW, 8'h7F);
        // Same register through the mono address pair
        read_chk(IDX_PRESET_ROW, 8'h7F, 1'b1);
        $display("test panning done");
        // Twelve-line frame, eight active, split at line 4, two-line text rows
        host_i.program_frame(12, 8, 8, 9);
        host_i.wr(IDX_MAX_SCAN, 8'h01);
        host_i.wr(IDX_LINE_CMP, 8'h04);
        host_i.wr(IDX_PRESET_ROW, 8'h01);
        host_i.wr(IDX_START_HIGH, 8'h12);
        host_i.wr(IDX_START_LOW, 8'h34);
        settle();
        repeat (11) host_i.line_pulse();
        #1;
        check(16'(line_count), 16'h000B);
        host_i.line_pulse();
        #1;
        check(16'(line_count), 16'h0000);
        check(mem_addr, 16'h1234);
        check(16'(row_scan), 16'h0001);
        check(16'(split_active), 16'h0000);
        for (int i = 1; i < 10; i++) begin
            host_i.line_pulse();
            #1;
            if (i <= 6) begin
                check(mem_addr, exp_mem[i]);
                check(16'(row_scan), 16'(exp_row[i]));
                check(16'(split_active), 16'(i >= 4));
            end
            check(16'(vactive), 16'(i <= 7));
            check(16'(vblank), 16'(i >= 8));
            check(16'(vsync), 16'(i >= 9));
        end
        $display("test split frame done");
        test_done();
    end

    // Extension nibbles 1..4 with every overflow and max-scan bit set
    task automatic std_chk_ext();
        host_i.wr(IDX_OVERFLOW, 8'hFF);
        host_i.wr(IDX_MAX_SCAN, 8'hFF);
        settle();
        check(16'(timing.vtotal), 16'h0111);
        check(16'(timing.vdisp_end), 16'h0222);
        check(16'(timing.vsync_start), 16'h0333);
        check(16'(timing.vblank_start), 16'h0444);
        check(16'(timing.line_cmp), 16'h0355);
    endtask
endmodule
